// [rtl/port_cfg_pkg.sv]
// Purpose : Shared constants for the upper-pin port configuration block.
// Assumes : APB with 32-bit data, one aligned word per register.
// Notes   : Printed offsets are register indexes; byte address is four times the index.
`default_nettype none
package port_cfg_pkg;
    // ----------------------------------------------------------------
    // Register indexes and byte addresses
    // ----------------------------------------------------------------
    localparam logic [31:0] FUNC_SEL_INDEX   = 32'h00ff0009;  // Mode register
    localparam logic [31:0] DIR_SEL_INDEX    = 32'h00fffff9;  // Direction register
    localparam logic [31:0] OUT_DATA_INDEX   = 32'h00ffffe9;  // Data register
    localparam logic [31:0] PULLUP_INDEX     = 32'h00ff0019;  // Pull-up register
    localparam logic [31:0] FUNC_SEL_ADDR    = FUNC_SEL_INDEX << 2;
    localparam logic [31:0] DIR_SEL_ADDR     = DIR_SEL_INDEX << 2;
    localparam logic [31:0] OUT_DATA_ADDR    = OUT_DATA_INDEX << 2;
    localparam logic [31:0] PULLUP_ADDR      = PULLUP_INDEX << 2;

    // ----------------------------------------------------------------
    // Field layout, write masks and reset values
    // ----------------------------------------------------------------
    localparam int          PIN_COUNT        = 4;      // Upper pins 7 to 4
    localparam int          UPPER_LSB        = 4;      // Upper pins sit in bits 7:4
    localparam int          ANALOG_ROUTE_POS = 2;      // Neighbour pin zero analog select
    localparam logic [7:0]  FUNC_SEL_MASK    = 8'hf4;  // Bits 3, 1, 0 reserved
    localparam logic [7:0]  UPPER_MASK       = 8'hf0;  // Bits 3 to 0 reserved
    localparam logic [7:0]  REG_RESET        = 8'h00;  // All registers clear on reset
endpackage : port_cfg_pkg
`default_nettype wire

// [rtl/pin_ctrl_if.sv]
// Purpose : Carries register state to the pin logic and pin levels back.
// Assumes : Single clock domain, same clock as the register file.
// Notes   : Levels only, no handshakes.
`timescale 1ns/100ps
`default_nettype none
interface pin_ctrl_if;
    logic [3:0] upperPinFunctionBits;   // 1 = mapped peripheral function
    logic [3:0] upperPinDirectionBits;  // 1 = output in general mode
    logic [3:0] pinOutputData;          // Stored output data
    logic [3:0] pinPullupEnable;        // Stored pull-up requests
    logic [3:0] pinLevelSync;           // Synchronised pin levels

    modport regs (output upperPinFunctionBits, output upperPinDirectionBits,
                  output pinOutputData, output pinPullupEnable, input pinLevelSync);
    modport pins (input upperPinFunctionBits, input upperPinDirectionBits,
                  input pinOutputData, input pinPullupEnable, output pinLevelSync);
endinterface : pin_ctrl_if
`default_nettype wire

// [rtl/pin_mux.sv]
// Purpose : Per-pin steering between general I/O and the mapped peripheral.
// Assumes : Pin inputs are asynchronous to clk.
// Notes   : Output path is combinational from register flops.
`timescale 1ns/100ps
`default_nettype none
module pin_mux (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Register side
    pin_ctrl_if.pins        ctrl,
    // Pad side
    input  wire logic [3:0] upperPortPinsIn,
    output logic      [3:0] upperPortPinsOut,
    output logic      [3:0] upperPortPinsOe,
    output logic      [3:0] pullupOn,
    // Peripheral side
    input  wire logic [3:0] periphOut,
    input  wire logic [3:0] periphOe,
    output logic      [3:0] periphIn
);
    // ----------------------------------------------------------------
    // Input synchroniser
    // ----------------------------------------------------------------
    logic [3:0] pinMeta;   // First stage, read only by the second
    logic [3:0] pinSync;   // Second stage, safe to use

    // Two flops in front of every consumer of the pad level
    always_ff @(posedge clk) begin
        if (rst) begin
            pinMeta <= 4'h0;
            pinSync <= 4'h0;
        end else begin
            pinMeta <= upperPortPinsIn;
            pinSync <= pinMeta;
        end
    end

    // ----------------------------------------------------------------
    // Steering
    // ----------------------------------------------------------------
    wire [3:0] gpioOe = ~ctrl.upperPinFunctionBits & ctrl.upperPinDirectionBits;
    wire [3:0] mapOe  = ctrl.upperPinFunctionBits & periphOe;

    assign ctrl.pinLevelSync = pinSync;
    // Mode bit picks the owner of each pad
    assign upperPortPinsOe  = gpioOe | mapOe;
    assign upperPortPinsOut = (ctrl.upperPinFunctionBits & periphOut)
                            | (~ctrl.upperPinFunctionBits & ctrl.pinOutputData);
    // Peripheral only sees the pad while it owns it
    assign periphIn = ctrl.upperPinFunctionBits & pinSync;
    // Pull-up only on pins that are inputs, whoever owns them
    assign pullupOn = ctrl.pinPullupEnable & ~upperPortPinsOe;
endmodule : pin_mux
`default_nettype wire

// [rtl/port_pin_config.sv]
// Purpose : APB register file and pin configuration for upper port pins 7 to 4.
// Assumes : Zero-wait APB slave; pads and peripherals outside this block.
// Notes   : Unmapped addresses answer with pslverr and read zero.
//
// Function
// - Mode bit picks general or mapped function
// - Analog route bit sends neighbour pin zero
// - Mode reserved bits read zero, ignored
// - Direction bit one makes general pin output
// - Direction low nibble reads zero, ignored
// - Pins usable as converter analog inputs
// - Mapping controller assigns pins 4 to 7
// - Data read: stored bit or live pin
// - Pull-up only on input pins
//
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module port_pin_config (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [31:0] prdata,
    // Upper port pins
    input  wire logic [3:0]  upperPortPinsIn,
    output logic      [3:0]  upperPortPinsOut,
    output logic      [3:0]  upperPortPinsOe,
    output logic      [3:0]  pullupOn,
    // Mapped peripheral functions
    input  wire logic [3:0]  periphOut,
    input  wire logic [3:0]  periphOe,
    output logic      [3:0]  periphIn,
    // Converter routing
    input  wire logic [3:0]  analogSample,
    output logic      [3:0]  analogInputEnable,
    output logic             analogInputZeroSel
);
    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [31:0] addr, input logic [31:0] target);
        hit = (addr == target);
    endfunction : hit

    wire selFunc   = hit(paddr, port_cfg_pkg::FUNC_SEL_ADDR);
    wire selDir    = hit(paddr, port_cfg_pkg::DIR_SEL_ADDR);
    wire selData   = hit(paddr, port_cfg_pkg::OUT_DATA_ADDR);
    wire selPullup = hit(paddr, port_cfg_pkg::PULLUP_ADDR);
    wire mapped    = selFunc | selDir | selData | selPullup;
    wire setupRd   = psel & ~penable & ~pwrite;          // Read data latched here
    wire accessWr  = psel & penable & pwrite & mapped;   // Write takes effect here
    // The full address must match, so no alias of a register can be hit;
    // only the low byte of the data word carries register bits.

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] pinFunctionSelect;   // Mode register, reserved bits kept zero
    logic [7:0] pinDirectionSelect;  // Direction register, low nibble kept zero
    logic [7:0] pinOutputData;       // Data register, low nibble kept zero
    logic [7:0] pinPullupEnable;     // Pull-up register, low nibble kept zero

    // Write masks keep reserved bits at zero so reads of them return zero
    wire [7:0] wByte = pwdata[7:0];
    wire [7:0] next_func = wByte & port_cfg_pkg::FUNC_SEL_MASK;
    wire [7:0] next_dir  = wByte & port_cfg_pkg::UPPER_MASK;
    wire [7:0] next_upr  = wByte & port_cfg_pkg::UPPER_MASK;

    // Register writes on the access edge only
    always_ff @(posedge clk) begin
        if (rst) begin
            pinFunctionSelect  <= port_cfg_pkg::REG_RESET;
            pinDirectionSelect <= port_cfg_pkg::REG_RESET;
            pinOutputData      <= port_cfg_pkg::REG_RESET;
            pinPullupEnable    <= port_cfg_pkg::REG_RESET;
        end else if (accessWr) begin
            if (selFunc)   pinFunctionSelect  <= next_func;
            if (selDir)    pinDirectionSelect <= next_dir;
            if (selData)   pinOutputData      <= next_upr;
            if (selPullup) pinPullupEnable    <= next_upr;
        end
    end

    // ----------------------------------------------------------------
    // Register checks
    // ----------------------------------------------------------------
    // A write lands whole in its access cycle, reserved bits dropped,
    // so software sees its own value on the next read
    a_func_write_lands: assert property (@(posedge clk) disable iff (rst)
        accessWr && selFunc
            |=> pinFunctionSelect == ($past(pwdata[7:0]) & port_cfg_pkg::FUNC_SEL_MASK))
        else $error("Mode register write lost");

    // Direction bits follow the written byte, low nibble dropped
    a_dir_write_lands: assert property (@(posedge clk) disable iff (rst)
        accessWr && selDir
            |=> pinDirectionSelect == ($past(pwdata[7:0]) & port_cfg_pkg::UPPER_MASK))
        else $error("Direction register write lost");

    // Stored output data follows the written byte
    a_data_write_lands: assert property (@(posedge clk) disable iff (rst)
        accessWr && selData
            |=> pinOutputData == ($past(pwdata[7:0]) & port_cfg_pkg::UPPER_MASK))
        else $error("Data register write lost");

    // Pull-up requests follow the written byte
    a_pull_write_lands: assert property (@(posedge clk) disable iff (rst)
        accessWr && selPullup
            |=> pinPullupEnable == ($past(pwdata[7:0]) & port_cfg_pkg::UPPER_MASK))
        else $error("Pull-up register write lost");

    // A stray write to an unmapped word must not disturb any register;
    // software bugs of that kind would otherwise reconfigure live pins
    a_unmapped_write_drop: assert property (@(posedge clk) disable iff (rst)
        psel && penable && pwrite && !mapped
            |=> $stable(pinFunctionSelect) && $stable(pinDirectionSelect)
                && $stable(pinOutputData) && $stable(pinPullupEnable))
        else $error("Unmapped write changed a register");

    // Reserved direction bits never hold a one
    a_dir_reserved_held: assert property (@(posedge clk) disable iff (rst)
        (pinDirectionSelect & ~port_cfg_pkg::UPPER_MASK) == 8'h00)
        else $error("Direction reserved bits not zero");

    // ----------------------------------------------------------------
    // Pin logic
    // ----------------------------------------------------------------
    pin_ctrl_if ctrlBus ();

    assign ctrlBus.upperPinFunctionBits  = pinFunctionSelect[7:4];
    assign ctrlBus.upperPinDirectionBits = pinDirectionSelect[7:4];
    assign ctrlBus.pinOutputData         = pinOutputData[7:4];
    assign ctrlBus.pinPullupEnable       = pinPullupEnable[7:4];

    pin_mux pinLogic (
        .clk              (clk),
        .rst              (rst),
        .ctrl             (ctrlBus),
        .upperPortPinsIn  (upperPortPinsIn),
        .upperPortPinsOut (upperPortPinsOut),
        .upperPortPinsOe  (upperPortPinsOe),
        .pullupOn         (pullupOn),
        .periphOut        (periphOut),
        .periphOe         (periphOe),
        .periphIn         (periphIn)
    );

    // A general pin must hide its level from the peripheral, which
    // could otherwise react to traffic that is not meant for it
    a_periph_in_masked: assert property (@(posedge clk) disable iff (rst)
        !pinFunctionSelect[6] |-> !periphIn[2])
        else $error("General pin level leaked to peripheral");

    // A mapped pin hands its synchronised level to the peripheral
    a_periph_in_follow: assert property (@(posedge clk) disable iff (rst)
        pinFunctionSelect[5] |-> periphIn[1] == ctrlBus.pinLevelSync[1])
        else $error("Mapped pin level not passed on");

    // General output on the top pin drives its stored bit
    a_gpio_drive_pin7: assert property (@(posedge clk) disable iff (rst)
        !pinFunctionSelect[7] && pinDirectionSelect[7]
            |-> upperPortPinsOe[3] && upperPortPinsOut[3] == pinOutputData[7])
        else $error("General output top pin not driving");

    // A pull-up against a driven pin only wastes current
    a_gpio_pull_output: assert property (@(posedge clk) disable iff (rst)
        !pinFunctionSelect[5] && pinDirectionSelect[5] |-> !pullupOn[1])
        else $error("Pull-up on general output pin");

    // A mapped input keeps its requested pull-up
    a_mapped_input_pull: assert property (@(posedge clk) disable iff (rst)
        pinFunctionSelect[6] && !periphOe[2] && pinPullupEnable[6] |-> pullupOn[2])
        else $error("Pull-up missing on mapped input pin");

    // ----------------------------------------------------------------
    // Converter routing
    // ----------------------------------------------------------------
    // A pin feeds either converter unit only while this block does not drive it (a board driver does not count);
    // a driven pin would corrupt the sample, so the request is dropped.
    assign analogInputEnable  = analogSample & ~upperPortPinsOe;
    // Neighbour pin zero goes to analog input zero when the bit is set
    assign analogInputZeroSel = pinFunctionSelect[port_cfg_pkg::ANALOG_ROUTE_POS];

    // A pin driven by this block never feeds the converter
    a_analog_driven_drop: assert property (@(posedge clk) disable iff (rst)
        upperPortPinsOe[1] |-> !analogInputEnable[1])
        else $error("Analog input enabled on driven pin");

    // The neighbour routing only moves on a mode register write, so a
    // conversion in progress is never switched away underneath it
    a_analog_route_hold: assert property (@(posedge clk) disable iff (rst)
        !(accessWr && selFunc) |=> $stable(analogInputZeroSel))
        else $error("Analog route changed without write");

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Output pins read the stored bit, input pins the synchronised level
    wire [3:0] dataView = (pinDirectionSelect[7:4] & pinOutputData[7:4])
                        | (~pinDirectionSelect[7:4] & ctrlBus.pinLevelSync);
    wire [7:0] readByte = selFunc   ? pinFunctionSelect  :
                          selDir    ? pinDirectionSelect :
                          selData   ? {dataView, 4'h0}   :
                          selPullup ? pinPullupEnable    : 8'h00;

    // Data is captured in the setup cycle so it comes from a flop
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (setupRd) begin
            prdata <= {24'h000000, readByte};
        end
    end

    // Zero wait states; unmapped addresses flag an error
    assign pready  = 1'h1;
    assign pslverr = psel & penable & ~mapped;

    // Output pins read back the stored bit, not the pad
    a_data_read_output: assert property (@(posedge clk) disable iff (rst)
        setupRd && selData && pinDirectionSelect[5]
            |=> prdata[5] == $past(pinOutputData[5]))
        else $error("Output pin data read wrong");

    // Unmapped reads return zero alongside the error flag
    a_unmapped_read_zero: assert property (@(posedge clk) disable iff (rst)
        setupRd && !mapped |=> prdata == 32'h00000000)
        else $error("Unmapped read not zero");

    // Reserved mode bits read back as zero
    a_func_reserved_read: assert property (@(posedge clk) disable iff (rst)
        setupRd && selFunc |=> (prdata[7:0] & ~port_cfg_pkg::FUNC_SEL_MASK) == 8'h00)
        else $error("Mode reserved bits read nonzero");

    // Only the low byte ever carries register bits
    a_prdata_upper_zero: assert property (@(posedge clk) disable iff (rst)
        prdata[31:8] == 24'h000000)
        else $error("Read data upper bytes nonzero");

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_mode_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        (pinFunctionSelect & ~port_cfg_pkg::FUNC_SEL_MASK) == 8'h00)
        else $error("Mode reserved bits not zero");

    a_dir_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        psel && !penable && !pwrite && selDir |=> prdata[3:0] == 4'h0)
        else $error("Direction low nibble read nonzero");

    a_reset_clears_cfg: assert property (@(posedge clk)
        rst |=> pinFunctionSelect == 8'h00 && pinDirectionSelect == 8'h00)
        else $error("Reset did not clear configuration");

    a_gpio_out_drive: assert property (@(posedge clk) disable iff (rst)
        !pinFunctionSelect[4] && pinDirectionSelect[4]
            |-> upperPortPinsOe[0] && upperPortPinsOut[0] == pinOutputData[4])
        else $error("General output pin not driving stored bit");

    a_gpio_input_float: assert property (@(posedge clk) disable iff (rst)
        !pinFunctionSelect[5] && !pinDirectionSelect[5] |-> !upperPortPinsOe[1])
        else $error("General input pin is driven");

    a_periph_owns_pin: assert property (@(posedge clk) disable iff (rst)
        pinFunctionSelect[7] |-> upperPortPinsOe[3] == periphOe[3]
            && upperPortPinsOut[3] == periphOut[3])
        else $error("Mapped pin not following peripheral");

    a_analog_route: assert property (@(posedge clk) disable iff (rst)
        accessWr && selFunc |=> analogInputZeroSel == $past(pwdata[2]))
        else $error("Analog route bit not applied");

    a_data_read_input: assert property (@(posedge clk) disable iff (rst)
        setupRd && selData && !pinDirectionSelect[6]
            |=> prdata[6] == $past(ctrlBus.pinLevelSync[2]))
        else $error("Input pin data read wrong");

    a_pullup_inputs: assert property (@(posedge clk) disable iff (rst)
        upperPortPinsOe != 4'h0 |-> (pullupOn & upperPortPinsOe) == 4'h0)
        else $error("Pull-up on driven pin");

    a_analog_no_drive: assert property (@(posedge clk) disable iff (rst)
        analogSample[0] && !upperPortPinsOe[0] |-> analogInputEnable[0])
        else $error("Analog request dropped on input pin");

    // After reset no pad is driven or pulled, and neighbour pin zero is not routed to the converter
    a_reset_pins_idle: assert property (@(posedge clk)
        rst |=> upperPortPinsOe == 4'h0 && pullupOn == 4'h0 && !analogInputZeroSel)
        else $error("Pins not idle after reset");
endmodule : port_pin_config
`default_nettype wire

// [tb/pad_periph_model.sv]
// Purpose : Stand-in for the pads and board wiring of the upper port pins.
// Assumes : Undriven pads sit low unless a pull-up is requested.
// Notes   : An outside driver only wins while the block leaves the pad alone.
`timescale 1ns/100ps
`default_nettype none
module pad_periph_model (
    // Block side
    input  wire logic [3:0] padOut,
    input  wire logic [3:0] padOe,
    input  wire logic [3:0] pullReq,
    // Board side
    input  wire logic [3:0] extDrive,
    input  wire logic [3:0] extLevel,
    // Resolved pad level
    output logic      [3:0] padLevel
);
    // ----------------------------------------------------------------
    // Pad resolution
    // ----------------------------------------------------------------
    // Block drive first, then board, then pull-up; a floating pad reads low
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (padOe[i]) padLevel[i] = padOut[i];
            else if (extDrive[i]) padLevel[i] = extLevel[i];
            else padLevel[i] = pullReq[i];
        end
    end
endmodule : pad_periph_model
`default_nettype wire

// [tb/port_a_pin_config_tb_top.sv]
// Purpose : Self-checking bench for the upper port pin configuration block.
// Assumes : Zero-wait APB slave; the master still waits for pready.
// Notes   : Register rows first, then pin behaviour and reset by hand.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin numErrors++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module port_a_pin_config_tb_top;
    localparam logic [31:0] MODE = port_cfg_pkg::FUNC_SEL_ADDR;  // Mode register
    localparam logic [31:0] DIR  = port_cfg_pkg::DIR_SEL_ADDR;   // Direction register
    localparam logic [31:0] DATA = port_cfg_pkg::OUT_DATA_ADDR;  // Data register
    localparam logic [31:0] PULL = port_cfg_pkg::PULLUP_ADDR;    // Pull-up register
    typedef struct {logic [31:0] a; logic [7:0] w; logic [31:0] r;} row_t;
    logic clk = 1'h0, rst, psel, penable, pwrite, pready, pslverr, zeroSel, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [3:0] pinIn, pinOut, pinOe, pullOn, pOut, pOe, pIn, aSmp, aEn, extDrv, extLvl;
    int numErrors = 0;
    int nCompared = 0;
    // Writable bits survive, reserved bits always read back as zero
    row_t rows [5] = '{'{MODE, 8'hff, 32'hf4}, '{DIR, 8'hff, 32'hf0},
        '{PULL, 8'hff, 32'hf0}, '{MODE, 8'h00, 32'h00}, '{DIR, 8'h0f, 32'h00}};

    // Free-running 5 ns clock
    always #2.5 clk = ~clk;

    port_pin_config dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .upperPortPinsIn(pinIn),
        .upperPortPinsOut(pinOut), .upperPortPinsOe(pinOe), .pullupOn(pullOn),
        .periphOut(pOut), .periphOe(pOe), .periphIn(pIn), .analogSample(aSmp),
        .analogInputEnable(aEn), .analogInputZeroSel(zeroSel));
    pad_periph_model model_u (.padOut(pinOut), .padOe(pinOe), .pullReq(pullOn),
        .extDrive(extDrv), .extLevel(extLvl), .padLevel(pinIn));

    // One APB transfer; an idle edge first keeps drivers from colliding
    task automatic apb(input logic wr, input logic [31:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // Let a register update reach the pins before looking
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up

    // Hang guard, far beyond the roughly 80 cycles the run needs
    initial begin
        repeat (5000) @(posedge clk);
        numErrors++;
        wrap_up();
    end

    // Main sequence
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'h1, 67'h0};
        {pOut, pOe, aSmp, extDrv, extLvl} = 20'h0;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        apb(1'h0, MODE, 8'h00);
        `CHK(rd, 32'h0)
        apb(1'h1, 32'h10, 8'hff);
        `CHK(err, 1'h1)
        apb(1'h0, 32'h10, 8'h00);
        `CHK({err, rd}, {1'h1, 32'h0})
        foreach (rows[i]) begin
            apb(1'h1, rows[i].a, rows[i].w);
            apb(1'h0, rows[i].a, 8'h00);
            `CHK(rd, rows[i].r)
        end
        // Pins 4,5 output, pins 6,7 input driven by the board as 0,1
        extDrv <= 4'hc;
        extLvl <= 4'h8;
        apb(1'h1, DATA, 8'h50);
        apb(1'h1, DIR, 8'h30);
        settle();
        `CHK({pinOe, pinOut & pinOe}, 8'h31)
        apb(1'h0, DATA, 8'h00);
        `CHK(rd, 32'h90)
        // Peripheral drives all its pins; it only matters once mapped
        pOe <= 4'hf;
        pOut <= 4'ha;
        apb(1'h1, PULL, 8'hf0);
        settle();
        `CHK(pullOn, 4'hc)
        // Hand pins 4,5 to the mapped peripheral
        apb(1'h1, MODE, 8'h30);
        aSmp <= 4'hf;
        settle();
        `CHK({pinOe, pinOut & pinOe, pIn}, 12'h322)
        apb(1'h1, MODE, 8'h04);
        settle();
        `CHK({zeroSel, aEn}, 5'h1c)
        // Reset in mid-run clears both configuration registers
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        #1;
        `CHK({pinOe, zeroSel}, 5'h0)
        apb(1'h0, DIR, 8'h00);
        `CHK(rd, 32'h0)
        apb(1'h0, MODE, 8'h00);
        `CHK(rd, 32'h0)
        wrap_up();
    end
endmodule : port_a_pin_config_tb_top
`default_nettype wire
